// >>> include/piso_defines.svh
// constants for the parallel-in serial-out shifter
`ifndef PISO_DEFINES_SVH
`define PISO_DEFINES_SVH
`define PISO_STAGES 8
`define PISO_LAST 7
`define PISO_RESET_VALUE 8'h00
// load released, shift clock and enable high: {load_n, clock, enable_n, serial}
`define PISO_CTRL_IDLE 4'hE
`endif

// >>> include/piso_pkg.sv
// types for the parallel-in serial-out shifter
`include "piso_defines.svh"
`default_nettype none
package piso_pkg;
	typedef logic [`PISO_LAST:0] piso_stages_type;
	typedef struct packed {
		logic parallel_load_n;
		logic shift_clock;
		logic clock_enable_n;
		logic serial_in;
	} piso_ctrl_type;
	typedef struct packed {
		logic true_oe_n;
		logic comp_oe_n;
	} piso_out_type;
endpackage
`default_nettype wire

// >>> logic/piso_shifter.sv
// eight-stage parallel-in serial-out shifter with open-drain outputs
`include "piso_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module piso_shifter (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic reset_i,
	// controller pins, asynchronous to sys_clk_i
	input wire piso_pkg::piso_ctrl_type ctrl_i,
	input wire logic [`PISO_LAST:0] parallel_in_i,
	// open-drain last-stage outputs: out is always 0, oe_n low while pulling
	output logic last_stage_out_o,
	output logic last_stage_out_oe_n_o,
	output logic last_stage_comp_o,
	output logic last_stage_comp_oe_n_o,
	// stage contents for observation
	output var piso_pkg::piso_stages_type stages_o
);
	// every pin passes two flops, so a pin change shows at the outputs
	// three clock edges later; the controller must hold each level of the
	// shift clock, enable and serial input for at least three cycles, or
	// an edge is lost. load is level sensitive here, not truly immediate:
	// the trade is full synchronous logic for a fixed three-cycle latency.
	// two-flop synchronisers on every pin
	piso_pkg::piso_ctrl_type ctrl_m_q;
	piso_pkg::piso_ctrl_type ctrl_s_q;
	logic [`PISO_LAST:0] par_m_q;
	logic [`PISO_LAST:0] par_s_q;
	logic eff_clk_q;
	logic eff_clk_d;
	piso_pkg::piso_stages_type stages_q;
	piso_pkg::piso_stages_type stages_d;
	logic true_oe_n_q;
	logic true_oe_n_d;
	logic comp_oe_n_q;
	logic comp_oe_n_d;
	logic rise;
	logic [`PISO_LAST:0] shifted;

	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i)
		begin
			// idle pins after reset: load released and the effective clock high,
			// so the first samples can neither load nor look like a rising edge
			ctrl_m_q <= `PISO_CTRL_IDLE;
			ctrl_s_q <= `PISO_CTRL_IDLE;
			par_m_q <= '0;
			par_s_q <= '0;
		end
		else
		begin
			ctrl_m_q <= ctrl_i;
			ctrl_s_q <= ctrl_m_q;
			par_m_q <= parallel_in_i;
			par_s_q <= par_m_q;
		end
	end

	// stage zero takes the serial input, every other stage its lower neighbour
	assign shifted[0] = ctrl_s_q.serial_in;
	for (genvar k = 1; k < `PISO_STAGES; k++)
	begin : g_stage
		assign shifted[k] = stages_q[k-1];
	end

	// an enable rising while the clock is low acts as a clock edge
	always_comb
	begin
		eff_clk_d = ctrl_s_q.shift_clock | ctrl_s_q.clock_enable_n;
		rise = eff_clk_d & ~eff_clk_q;
		stages_d = stages_q;
		if (!ctrl_s_q.parallel_load_n)
			stages_d = par_s_q;
		else if (rise)
			stages_d = shifted;
		true_oe_n_d = stages_d[`PISO_LAST];
		comp_oe_n_d = ~stages_d[`PISO_LAST];
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i)
		begin
			eff_clk_q <= 1'h1;
			stages_q <= `PISO_RESET_VALUE;
			true_oe_n_q <= 1'h0;
			comp_oe_n_q <= 1'h1;
		end
		else
		begin
			eff_clk_q <= eff_clk_d;
			stages_q <= stages_d;
			true_oe_n_q <= true_oe_n_d;
			comp_oe_n_q <= comp_oe_n_d;
		end
	end

	assign last_stage_out_o = 1'h0;
	assign last_stage_comp_o = 1'h0;
	assign last_stage_out_oe_n_o = true_oe_n_q;
	assign last_stage_comp_oe_n_o = comp_oe_n_q;
	assign stages_o = stages_q;

	sequence s_rise;
		ctrl_s_q.parallel_load_n && !eff_clk_q && eff_clk_d;
	endsequence

	a_shift_moves_up: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		s_rise |=> stages_q == {$past(stages_q[`PISO_LAST-1:0]), $past(ctrl_s_q.serial_in)})
		else $error("shift did not move stages up");
	a_load_copies: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		!ctrl_s_q.parallel_load_n |=> stages_q == $past(par_s_q))
		else $error("parallel load not copied");
	a_enable_holds: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		ctrl_s_q.parallel_load_n && eff_clk_q && ctrl_s_q.clock_enable_n |=> $stable(stages_q))
		else $error("stages changed while disabled");
	a_no_edge_hold: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		ctrl_s_q.parallel_load_n && !(!eff_clk_q && eff_clk_d) |=> $stable(stages_q))
		else $error("stages changed without edge");
	a_serial_entry: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		s_rise |=> stages_q[0] == $past(ctrl_s_q.serial_in))
		else $error("serial input not in stage zero");
	a_true_out: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		last_stage_out_oe_n_o == stages_q[`PISO_LAST])
		else $error("true output wrong");
	a_comp_out: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		comp_oe_n_q != true_oe_n_q)
		else $error("outputs not complementary");
	a_enable_edge: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		ctrl_s_q.parallel_load_n && !eff_clk_q && !ctrl_s_q.shift_clock
		&& ctrl_s_q.clock_enable_n |=> stages_q[0] == $past(ctrl_s_q.serial_in))
		else $error("enable edge did not shift");

	// further checks: enable-driven edges, held clocks, load and outputs
	sequence s_enable_rise;
		ctrl_s_q.parallel_load_n && !eff_clk_q && !ctrl_s_q.shift_clock
		&& ctrl_s_q.clock_enable_n;
	endsequence

	// a load that stays low over two samples
	sequence s_load_held;
		!ctrl_s_q.parallel_load_n ##1 !ctrl_s_q.parallel_load_n;
	endsequence

	// shift clock parked high with load released
	sequence s_high_clock;
		ctrl_s_q.parallel_load_n && ctrl_s_q.shift_clock && eff_clk_q;
	endsequence

	a_last_from_six: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		s_rise |=> stages_q[`PISO_LAST] == $past(stages_q[`PISO_LAST-1]))
		else $error("last stage did not take stage six");
	a_comp_level: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		last_stage_comp_oe_n_o == ~stages_q[`PISO_LAST])
		else $error("complement output level wrong");
	a_drain_low: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		last_stage_out_o == 1'h0 && last_stage_comp_o == 1'h0)
		else $error("open-drain output drove high");
	a_high_clock_holds: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		s_high_clock |=> $stable(stages_q))
		else $error("stages changed with shift clock high");
	a_load_steady: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		s_load_held |=> stages_q == $past(par_s_q))
		else $error("held load did not follow inputs");
	a_enable_shift: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		s_enable_rise |=> stages_q == {$past(stages_q[`PISO_LAST-1:0]), $past(ctrl_s_q.serial_in)})
		else $error("enable edge did not move stages up");
	a_load_output: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		!ctrl_s_q.parallel_load_n |=> last_stage_out_oe_n_o == $past(par_s_q[`PISO_LAST]))
		else $error("load did not reach true output");
	a_hold_outputs: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		ctrl_s_q.parallel_load_n && !rise |=> $stable(true_oe_n_q) && $stable(comp_oe_n_q))
		else $error("outputs changed without shift");
	a_reset_idle: assert property (@(posedge sys_clk_i)
		reset_i |=> stages_q == `PISO_RESET_VALUE && true_oe_n_q == 1'h0)
		else $error("reset did not clear stages");

	// each stage above zero checked on its own so a single broken link is named
	for (genvar j = 1; j < `PISO_STAGES; j++)
	begin : g_stage_check
		a_stage_moves: assert property (@(posedge sys_clk_i) disable iff (reset_i)
			s_rise |=> stages_q[j] == $past(stages_q[j-1]))
			else $error("stage did not take its lower neighbour");
	end
endmodule // piso_shifter
`default_nettype wire

// >>> sim/piso_ctrl_model.sv
// controller model driving the shifter pins
`timescale 1ns/1ps
`default_nettype none
module piso_ctrl_model (
	// clock
	input wire logic sys_clk_i,
	// pins toward the shifter
	output var piso_pkg::piso_ctrl_type ctrl_o,
	output logic [7:0] par_o
);
	initial ctrl_o = 4'h8;
	initial par_o = 8'h00;
	// each level held five cycles, above the three the synchroniser needs
	task drive(input logic ld_n, ck, ce_n, s, input logic [7:0] p);
		@(posedge sys_clk_i);
		par_o <= p;
		ctrl_o <= {ld_n, ck, ce_n, s};
		repeat (4) @(posedge sys_clk_i);
	endtask
endmodule // piso_ctrl_model
`default_nettype wire

// >>> sim/test_piso_shifter.sv
// self-checking bench for the shifter
`timescale 1ns/1ps
`default_nettype none
module test_piso_shifter;
	logic sys_clk_i = 1'b0;
	logic reset_i = 1'b1;
	int err_total = 0;
	int total_checks = 0;
	piso_pkg::piso_ctrl_type ctrl;
	logic [7:0] par;
	logic od_o, od_oe_n, cp_o, cp_oe_n;
	piso_pkg::piso_stages_type stages;
	always #4 sys_clk_i = ~sys_clk_i;
	piso_ctrl_model u_ctl (.sys_clk_i(sys_clk_i), .ctrl_o(ctrl), .par_o(par));
	piso_shifter u_dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .ctrl_i(ctrl),
		.parallel_in_i(par), .last_stage_out_o(od_o), .last_stage_out_oe_n_o(od_oe_n),
		.last_stage_comp_o(cp_o), .last_stage_comp_oe_n_o(cp_oe_n), .stages_o(stages));
	task chk(input logic [7:0] e);
		#1;
		total_checks++;
		if ({od_o, cp_o, od_oe_n, cp_oe_n, stages} !== {2'b00, e[7], ~e[7], e})
		begin
			err_total++;
			$display("CHECK FAILED outputs expected %h seen %h", {2'b00, e[7], ~e[7], e},
				{od_o, cp_o, od_oe_n, cp_oe_n, stages});
		end
	endtask
	task t_load(input logic [7:0] v);
		u_ctl.drive(1, 0, 0, 0, v);
		u_ctl.drive(0, 1, 1, 1, v);
		chk(v);
		u_ctl.drive(1, 0, 0, 0, v);
		chk(v);
		$display("load test done");
	endtask
	task t_shift;
		u_ctl.drive(1, 0, 0, 1, 8'hFF);
		u_ctl.drive(1, 1, 0, 1, 8'hFF);
		chk(8'h4B);
		u_ctl.drive(1, 0, 0, 0, 8'hFF);
		u_ctl.drive(1, 1, 0, 0, 8'hFF);
		chk(8'h96);
		$display("shift test done");
	endtask
	task t_enable;
		u_ctl.drive(1, 0, 0, 1, 8'h00);
		u_ctl.drive(1, 0, 1, 1, 8'h00);
		chk(8'h2D);
		u_ctl.drive(1, 1, 1, 0, 8'h00);
		u_ctl.drive(1, 0, 1, 0, 8'h00);
		u_ctl.drive(1, 1, 1, 0, 8'h00);
		chk(8'h2D);
		u_ctl.drive(1, 1, 0, 0, 8'h00);
		chk(8'h2D);
		$display("enable test done");
	endtask
	task summarize;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial
	begin
		repeat (10) @(posedge sys_clk_i);
		reset_i <= 1'b0;
		t_load(8'h5A);
		t_load(8'hA5);
		t_shift;
		t_enable;
		summarize;
	end
	initial
	begin
		#20000;
		err_total++;
		summarize;
	end
endmodule // test_piso_shifter
`default_nettype wire
